/* File: verilog/eci_top.sv */
// Function
// - Switchable state outputs follow global polarity
// - Polarity setting is negative or positive
// - Step sync code drives two bits
// - Memory number from two select bits
// - Modes disabled, enabled, peripheral control
// - Trigger pulse polarity and width configurable
// - Port functions and peripheral mode exclusive
// - Peripheral mode drives quick-change sync
// - Status sync during quick-change, same as quick-change sync
// - Control inputs act on falling edge
// - Inputs ignored under communication remote
// - Disabled mode ignores inputs, keeps status
`timescale 1ns/100ps
`default_nettype none
`include "eci_params.svh"
module eci_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device state from the core, same clock
  input wire logic power_on,
  input wire logic out_on,
  input wire logic prot_active,
  input wire logic limiter_active,
  input wire logic auto_gain_regulation,
  input wire logic sw_busy,
  input wire logic range_100v,
  input wire logic [1:0] step_code,
  input wire logic quick_sync,
  input wire logic trig_req,
  // Control pins: off,on,start,stop,hold,br1,br2,recall,pkclr
  input wire logic [8:0] ctl_pin,
  input wire logic [1:0] mem_pin,
  // Status pins
  output logic [10:0] stat_pin,
  // Peripheral sync pins
  output logic qc_sync_pin,
  output logic status_sync_pin,
  // Command pulses to the core
  output logic [8:0] cmd_pulse,
  output logic [1:0] cmd_mem_sel
);
  // Clean input events
  eci_in_if in_bus ();
  assign in_bus.pin = ctl_pin;
  eci_in_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .io(in_bus),
    .mem_pin(mem_pin)
  );

  // Registers
  logic [31:0] ctrl_reg, ctrl_next, width_reg, width_next;
  logic [8:0] evt_reg, evt_next;
  logic [31:0] tcnt_reg, tcnt_next;
  eci_pkg::eci_trg_t trg_reg, trg_next;
  logic trig_reg, trig_next;
  logic [10:0] stat_reg, stat_next;
  logic qc_reg, qc_next, ss_reg, ss_next;
  logic [8:0] cmd_reg, cmd_next;
  logic [1:0] mem_reg, mem_next;
  // Bus state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next, bv_reg, bv_next;
  logic [3:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;

  // Decoded control fields
  eci_pkg::eci_mode_t mode;
  logic pol_pos, tpol_pos, remote, fire;
  assign mode = eci_pkg::eci_mode_t'(ctrl_reg[`ECI_CTRL_MODE_LSB +: 2]);
  assign pol_pos = ctrl_reg[`ECI_CTRL_POL_BIT];
  assign tpol_pos = ctrl_reg[`ECI_CTRL_TPOL_BIT];
  assign remote = ctrl_reg[`ECI_CTRL_REMOTE_BIT];
  logic inputs_live;
  // Inputs act only in enabled mode without communication remote
  assign inputs_live = (mode == eci_pkg::ECI_MODE_ENABLE) && !remote;

  // Handshake outputs
  assign s_axi_awready = !aw_hold_reg && !bv_reg;
  assign s_axi_wready = !w_hold_reg && !bv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;

  // Write strobe merge helper
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bus slave and register next state
  always_comb begin
    logic do_wr;
    do_wr = 1'b0;
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    ctrl_next = ctrl_reg;
    ctrl_next[`ECI_CTRL_FIRE_BIT] = 1'b0;
    width_next = width_reg;
    // Events set sticky; set wins over clear
    evt_next = evt_reg;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    // Perform write once both are held
    if (aw_hold_reg && w_hold_reg) begin
      do_wr = 1'b1;
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bv_next = 1'b1;
      br_next = `ECI_RESP_OK;
      case (awa_reg)
        `ECI_ADDR_CTRL: ctrl_next = merge(ctrl_reg, wd_reg, ws_reg) & 32'h0000011F;
        `ECI_ADDR_TRIG: width_next = merge(width_reg, wd_reg, ws_reg);
        `ECI_ADDR_EVENT: evt_next = evt_reg & ~(wd_reg[8:0] & {ws_reg[1], {8{ws_reg[0]}}});
        `ECI_ADDR_STATE: br_next = `ECI_RESP_OK;
        default: br_next = `ECI_RESP_SLVERR;
      endcase
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    evt_next = evt_next | (in_bus.fall & {9{inputs_live}});
    // Read path
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end else if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = `ECI_RESP_OK;
      case (s_axi_araddr)
        `ECI_ADDR_CTRL: rd_next = ctrl_reg;
        `ECI_ADDR_TRIG: rd_next = width_reg;
        `ECI_ADDR_STATE: rd_next = {19'h0, mem_reg, stat_reg};
        `ECI_ADDR_EVENT: rd_next = {23'h0, evt_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = `ECI_RESP_SLVERR;
        end
      endcase
    end
    fire = do_wr && (awa_reg == `ECI_ADDR_CTRL) && ws_reg[1] && wd_reg[`ECI_CTRL_FIRE_BIT];
  end

  // Status, sync, command and trigger next state
  always_comb begin
    logic [4:0] sw;
    sw = {sw_busy, auto_gain_regulation, limiter_active, prot_active, out_on};
    // Negative polarity drives active states low
    sw = pol_pos ? sw : ~sw;
    // Top bit is an unused pin and stays low
    stat_next = {1'b0, trig_reg, step_code, range_100v, sw, power_on};
    // Sync lines only in peripheral control mode
    qc_next = (mode == eci_pkg::ECI_MODE_PERIPH) && quick_sync;
    ss_next = (mode == eci_pkg::ECI_MODE_PERIPH) && quick_sync;
    cmd_next = in_bus.fall & {9{inputs_live}};
    mem_next = inputs_live ? in_bus.mem_sel : mem_reg;
    trg_next = trg_reg;
    tcnt_next = tcnt_reg;
    trig_next = !tpol_pos;
    // Pulse of width_reg microseconds
    case (trg_reg)
      eci_pkg::ECI_TRG_IDLE: begin
        if (trig_req || fire) begin
          trg_next = eci_pkg::ECI_TRG_BUSY;
          tcnt_next = width_reg * 32'(`ECI_CLK_MHZ);
          trig_next = tpol_pos;
        end
      end
      eci_pkg::ECI_TRG_BUSY: begin
        if (tcnt_reg <= 32'h1) begin
          trg_next = eci_pkg::ECI_TRG_IDLE;
        end else begin
          tcnt_next = tcnt_reg - 32'h1;
          trig_next = tpol_pos;
        end
      end
      default: trg_next = eci_pkg::ECI_TRG_IDLE;
    endcase
  end

  // Register all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `ECI_CTRL_RESET;
      width_reg <= `ECI_TRIG_RESET;
      evt_reg <= 9'h000;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= 2'h0;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= 2'h0;
      stat_reg <= 11'h200;
      qc_reg <= 1'b0;
      ss_reg <= 1'b0;
      cmd_reg <= 9'h000;
      mem_reg <= 2'h0;
      trg_reg <= eci_pkg::ECI_TRG_IDLE;
      tcnt_reg <= 32'h0;
      trig_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      width_reg <= width_next;
      evt_reg <= evt_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      stat_reg <= stat_next;
      qc_reg <= qc_next;
      ss_reg <= ss_next;
      cmd_reg <= cmd_next;
      mem_reg <= mem_next;
      trg_reg <= trg_next;
      tcnt_reg <= tcnt_next;
      trig_reg <= trig_next;
    end
  end

  // Outputs
  assign stat_pin = stat_reg;
  assign qc_sync_pin = qc_reg;
  assign status_sync_pin = ss_reg;
  assign cmd_pulse = cmd_reg;
  assign cmd_mem_sel = mem_reg;
endmodule : eci_top
`default_nettype wire

/* File: verilog/eci_params.svh */
`ifndef ECI_PARAMS_SVH
`define ECI_PARAMS_SVH
// Register byte addresses
`define ECI_ADDR_CTRL 4'h0
`define ECI_ADDR_TRIG 4'h4
`define ECI_ADDR_STATE 4'h8
`define ECI_ADDR_EVENT 4'hC
// Control register fields
`define ECI_CTRL_MODE_LSB 0
`define ECI_CTRL_POL_BIT 2
`define ECI_CTRL_TPOL_BIT 3
`define ECI_CTRL_REMOTE_BIT 4
`define ECI_CTRL_FIRE_BIT 8
`define ECI_CTRL_RESET 32'h00000000
// Trigger width register reset: 10.0 ms in microseconds
`define ECI_TRIG_WIDTH_US 10000
`define ECI_CLK_MHZ 125
`define ECI_TRIG_RESET 32'h00002710
// Input noise filter length in cycles
`define ECI_FILT_LEN 4
// Bus response codes: okay, and the unmapped address answer
`define ECI_RESP_OK 2'h0
`define ECI_RESP_SLVERR 2'h2
`endif

/* File: verilog/eci_pkg.sv */
package eci_pkg;
  // External control modes
  typedef enum logic [1:0] {
    ECI_MODE_DISABLE = 2'h0,
    ECI_MODE_ENABLE = 2'h1,
    ECI_MODE_PERIPH = 2'h2
  } eci_mode_t;
  // Trigger pulse generator states
  typedef enum logic [0:0] {
    ECI_TRG_IDLE = 1'h0,
    ECI_TRG_BUSY = 1'h1
  } eci_trg_t;
endpackage : eci_pkg

/* File: verilog/eci_in_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Raw pins in, clean falling-edge pulses out
interface eci_in_if;
  logic [8:0] pin;
  logic [8:0] fall;
  logic [1:0] mem_sel;
  modport filt (input pin, output fall, output mem_sel);
  modport user (output pin, input fall, input mem_sel);
endinterface : eci_in_if
`default_nettype wire

/* File: verilog/eci_in_filter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "eci_params.svh"
// Synchroniser, noise filter and falling-edge detector per control pin; memory select pins get the synchroniser only
module eci_in_filter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and clean events
  eci_in_if.filt io,
  // Memory select pins
  input wire logic [1:0] mem_pin
);
  // Memory select synchronisers
  logic [1:0] ms1_reg, ms1_next, ms2_reg, ms2_next;
  always_comb begin
    ms1_next = mem_pin;
    ms2_next = ms1_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms1_reg <= 2'h0;
      ms2_reg <= 2'h0;
    end else begin
      ms1_reg <= ms1_next;
      ms2_reg <= ms2_next;
    end
  end
  assign io.mem_sel = ms2_reg;
  genvar i;
  generate
    for (i = 0; i < 9; i++) begin : g_in
      // Two-flop sync, filter counter, stable level
      logic s1_reg, s1_next, s2_reg, s2_next, lvl_reg, lvl_next, fall_reg, fall_next;
      logic [2:0] cnt_reg, cnt_next;
      always_comb begin
        s1_next = io.pin[i];
        s2_next = s1_reg;
        lvl_next = lvl_reg;
        cnt_next = cnt_reg;
        fall_next = 1'b0;
        // Level accepted only after it holds for the filter length
        if (s2_reg == lvl_reg) begin
          cnt_next = 3'h0;
        end else if (cnt_reg == 3'(`ECI_FILT_LEN - 1)) begin
          cnt_next = 3'h0;
          lvl_next = s2_reg;
          fall_next = lvl_reg & ~s2_reg;
        end else begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          lvl_reg <= 1'b1;
          cnt_reg <= 3'h0;
          fall_reg <= 1'b0;
        end else begin
          s1_reg <= s1_next;
          s2_reg <= s2_next;
          lvl_reg <= lvl_next;
          cnt_reg <= cnt_next;
          fall_reg <= fall_next;
        end
      end
      assign io.fall[i] = fall_reg;
    end
  endgenerate
endmodule : eci_in_filter
`default_nettype wire

/* File: verif/eci_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the control port
module eci_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core inputs and pins
  input wire logic out_on,
  input wire logic prot_active,
  input wire logic [1:0] step_code,
  input wire logic quick_sync,
  input wire logic [8:0] ctl_pin,
  // Outputs
  input wire logic [10:0] stat_pin,
  input wire logic qc_sync_pin,
  input wire logic status_sync_pin,
  input wire logic [8:0] cmd_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Switchable bits share one inversion
  property p_pol;
    $past(aresetn, 2) |-> ((stat_pin[1] ^ $past(out_on)) == (stat_pin[2] ^ $past(prot_active)));
  endproperty
  a_pol: assert property (p_pol) else $error("state bits disagree on polarity");
  property p_step;
    $past(aresetn, 2) |-> stat_pin[8:7] == $past(step_code);
  endproperty
  a_step: assert property (p_step) else $error("step code bits wrong");
  property p_qc;
    qc_sync_pin |-> $past(quick_sync);
  endproperty
  a_qc: assert property (p_qc) else $error("sync pin without cause");
  property p_pair;
    status_sync_pin == qc_sync_pin;
  endproperty
  a_pair: assert property (p_pair) else $error("status sync differs");
  property p_excl;
    (qc_sync_pin || status_sync_pin) |-> cmd_pulse == 9'h000;
  endproperty
  a_excl: assert property (p_excl) else $error("command in peripheral mode");
  property p_once;
    (cmd_pulse & $past(cmd_pulse)) == 9'h000;
  endproperty
  a_once: assert property (p_once) else $error("command pulse too long");
  property p_fall;
    (cmd_pulse & $past(ctl_pin, 5)) == 9'h000;
  endproperty
  a_fall: assert property (p_fall) else $error("command without low pin");
  property p_trig;
    $changed(stat_pin[9]) |=> $stable(stat_pin[9]) [*8];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger level too short");
  // Main scenarios
  c_pulse: cover property (cmd_pulse != 9'h000);
  c_qc: cover property (qc_sync_pin);
  c_trig: cover property ($fell(stat_pin[9]));
endmodule : eci_top_props
bind eci_top eci_top_props u_props (.aclk(aclk), .aresetn(aresetn), .out_on(out_on),
  .prot_active(prot_active), .step_code(step_code), .quick_sync(quick_sync),
  .ctl_pin(ctl_pin), .stat_pin(stat_pin), .qc_sync_pin(qc_sync_pin),
  .status_sync_pin(status_sync_pin), .cmd_pulse(cmd_pulse));
`default_nettype wire

/* File: verif/eci_ext_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// External controller on the control pins
module eci_ext_ctrl (
  // Clock and start gate
  input wire logic aclk,
  input wire logic armed,
  // Request
  input wire logic go,
  input wire logic [3:0] sel,
  input wire logic [7:0] width,
  input wire logic [1:0] mem,
  // Pins
  output logic [8:0] ctl_pin,
  output logic [1:0] mem_pin
);
  logic [7:0] cnt = 8'h00; // Low time left
  initial ctl_pin = 9'h1FF;
  initial mem_pin = 2'h0;
  // Pull one pin low for width cycles, idle high
  always @(posedge aclk) begin
    mem_pin <= mem;
    if (go && armed) begin
      ctl_pin[sel] <= 1'b0;
      cnt <= width;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else if (cnt == 8'h01) begin
      ctl_pin <= 9'h1FF;
      cnt <= 8'h00;
    end
  end
endmodule : eci_ext_ctrl
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk = 0, aresetn = 0, dev_up = 0, go = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, sel = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmd_mem_sel, mem_pin, step_code = 2'h0, mem = 2'h0;
  logic power_on = 0, out_on = 0, prot_active = 0, limiter_active = 0, sw_busy = 0;
  logic auto_gain_regulation = 0, range_100v = 0, quick_sync = 0, trig_req = 0;
  logic [7:0] width = 8'h00;
  logic [8:0] ctl_pin, cmd_pulse;
  logic [10:0] stat_pin;
  logic qc_sync_pin, status_sync_pin;
  logic [33:0] exp_bus[$]; // Expected response and read data
  logic [10:0] exp_cmd[$]; // Expected memory select and command
  int bad_count = 0, total_checks = 0, cyc = 0, n;
  integer seed = 32'h9322BE0D;
  // Clock
  always #4 aclk = ~aclk;
  eci_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_on, .out_on, .prot_active, .limiter_active, .auto_gain_regulation,
    .sw_busy, .range_100v, .step_code, .quick_sync, .trig_req, .ctl_pin, .mem_pin, .stat_pin,
    .qc_sync_pin, .status_sync_pin, .cmd_pulse, .cmd_mem_sel);
  eci_ext_ctrl u_ext (.aclk, .armed(dev_up), .go, .sel, .width, .mem, .ctl_pin, .mem_pin);
  // Compare and count
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Write with both channels offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    exp_bus.push_back(34'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | (s_axi_awvalid & s_axi_awready);
      wd = wd | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 1;
    do begin @(negedge aclk); ad = s_axi_bvalid; @(posedge aclk); end while (!ad);
    s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
    logic t;
    exp_bus.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin @(negedge aclk); t = s_axi_arready; @(posedge aclk); end while (!t);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do begin @(negedge aclk); t = s_axi_rvalid; @(posedge aclk); end while (!t);
    s_axi_rready <= 0;
  endtask : axi_rd
  // One falling edge on a pin, memory select set beforehand
  task automatic pin_fall(input int i, input int w, input bit fire);
    logic [1:0] m;
    m = $random(seed);
    mem <= m;
    repeat (12) @(posedge aclk);
    sel <= 4'(i);
    width <= 8'(w);
    go <= 1;
    if (fire) exp_cmd.push_back({m, 9'(1 << i)});
    @(posedge aclk);
    go <= 0;
    repeat (w + 14) @(posedge aclk);
  endtask : pin_fall
  // Results monitor
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_bus.pop_front());
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_bus.pop_front());
    if (cmd_pulse != 9'h000) check({cmd_mem_sel, cmd_pulse}, exp_cmd.pop_front());
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    dev_up <= 1;
    @(posedge aclk);
    axi_rd(4'h0, 34'h0);
    axi_rd(4'h4, {2'h0, 32'h00002710});
    axi_rd(4'h2, {2'h2, 32'h0});
    // State outputs under both polarities
    for (int p = 0; p < 2; p++) begin
      axi_wr(4'h0, 32'(p << 2));
      repeat (4) begin
        {range_100v, sw_busy, auto_gain_regulation, limiter_active, prot_active, out_on,
          power_on} <= $random(seed);
        step_code <= $random(seed);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        check(stat_pin[8:0], {step_code, range_100v, {sw_busy, auto_gain_regulation,
          limiter_active, prot_active, out_on} ^ {5{p == 0}}, power_on});
        @(posedge aclk);
      end
    end
    // Disabled, enabled, peripheral, remote
    for (int k = 0; k < 4; k++) begin
      axi_wr(4'h0, (k == 3) ? 32'h11 : 32'(k));
      pin_fall(k, 10, k == 1);
    end
    axi_wr(4'h0, 32'h1);
    for (int i = 0; i < 9; i++) pin_fall(i, 8, 1);
    pin_fall(3, 2, 0);
    // Sticky event flags, then write one to clear
    axi_rd(4'hC, {2'h0, 32'h000001FF});
    axi_wr(4'hC, 32'h000001FF);
    axi_rd(4'hC, 34'h0);
    // Trigger width and both polarities, by request and by fire bit
    axi_wr(4'h4, 32'h1);
    for (int t = 0; t < 2; t++) begin
      axi_wr(4'h0, 32'(1 | (t << 3)));
      repeat (10) @(posedge aclk);
      if (t == 0) begin trig_req <= 1; @(posedge aclk); trig_req <= 0; end
      else axi_wr(4'h0, 32'h109);
      for (n = 0; stat_pin[9] !== t[0] && n < 300; n++) @(negedge aclk);
      for (n = 0; stat_pin[9] === t[0] && n < 300; n++) @(negedge aclk);
      check(n, 125);
      @(posedge aclk);
    end
    axi_rd(4'h0, {2'h0, 32'h9});
    // Quick-change sync only in peripheral mode
    for (int m = 1; m < 3; m++) begin
      axi_wr(4'h0, 32'(m));
      quick_sync <= 1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check({qc_sync_pin, status_sync_pin}, {2{m == 2}});
      @(posedge aclk);
      quick_sync <= 0;
    end
    check(exp_cmd.size(), 0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
